// >>> verilog/i2c_slave_cfg.svh
// Offsets, field positions, reset values and counts of the I2C slave
// Summary of operation
// [RULE1] Direction bit one: slave transmits
// [RULE2] Direction bit zero: slave receives
// [RULE3] Address match: drive acknowledge after address
// [RULE4] Master stops after missing address acknowledge
// [RULE5] Match sets transmit select from direction
// [RULE6] Eight-bit bytes, most significant bit first
// [RULE7] Receiver drives ack_to_send on ninth clock
// [RULE8] Transmitter releases SDA on missing acknowledge
// [RULE9] Bytes pass through the serial data register
// [RULE10] Data register access releases held SCL
// [RULE11] Counter starts on match, clears on SCL fall
// [RULE12] Time-out when period passes without SCL fall
// [RULE13] STOP condition stops time-out counting
// [RULE14] Overflow: halt, disable, flag, interrupt
// [RULE15] Time-out resets second control register only
// [RULE16] Software clears flag via time-out register
// [RULE17] Period is (select+1) times 32 slow clocks
// [RULE18] Enable bit7, flag bit6, select bits5-0
// [RULE19] Seven-bit address compare, capture direction, interrupt
// [RULE20] ack_received_n zero when ninth-clock ack seen
// [RULE21] Hold SCL low until release access
`ifndef I2C_SLAVE_CFG_SVH
`define I2C_SLAVE_CFG_SVH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_CTRL_FIRST 5'h00
`define OFS_CTRL_SECOND 5'h04
`define OFS_SLAVE_ADDR 5'h08
`define OFS_DATA 5'h0C
`define OFS_TIMEOUT 5'h10
// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define C1_ENABLE 0
`define C2_ACK_RCVD_N 0
`define C2_RW_DIR 2
`define C2_ACK_TO_SEND 3
`define C2_TX_SELECT 4
`define C2_BUSY 5
`define C2_ADDRESSED 6
`define TOC_EN 7
`define TOC_FLAG 6
`define C1_RESET 8'h00
`define C2_RESET 8'h00
`define TOC_RESET 8'h00
`define SADDR_RESET 8'h00
// ----------------------------------------------------------------
// Counts
// ----------------------------------------------------------------
`define TO_PRESCALE 32
`define BYTE_BITS 4'h8
`endif

// >>> verilog/i2c_slave_pkg.sv
// Types shared by the I2C slave modules
`default_nettype none
package i2c_slave_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_ADDR_ACK = 3'b010,
		ST_RX = 3'b011,
		ST_RX_ACK = 3'b100,
		ST_TX = 3'b101,
		ST_TX_ACK = 3'b110,
		ST_WAIT_STOP = 3'b111
	} slave_state_t;
	typedef logic [5:0] period_t;
endpackage : i2c_slave_pkg
`default_nettype wire

// >>> verilog/timeout_if.sv
// Signals between the slave engine and its time-out counter
`timescale 1ns/10ps
`default_nettype none
interface timeout_if;
	logic start;
	logic scl_fall;
	logic stop;
	logic en;
	logic fsub_tick;
	i2c_slave_pkg::period_t period;
	logic overflow;
	modport engine (output start, scl_fall, stop, en, fsub_tick, period,
		input overflow);
	modport counter (input start, scl_fall, stop, en, fsub_tick, period,
		output overflow);
endinterface : timeout_if
`default_nettype wire

// >>> verilog/bus_timeout_counter.sv
// Bus time-out counter clocked by slow-clock ticks divided by 32
`timescale 1ns/10ps
`default_nettype none
`include "i2c_slave_cfg.svh"
module bus_timeout_counter (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	// Engine side
	timeout_if.counter t
);
	localparam logic [4:0] PRE_LAST = 5'(`TO_PRESCALE - 1);
	logic running_ff;
	logic [4:0] pre_ff;
	i2c_slave_pkg::period_t cnt_ff;
	logic ovf_ff;
	logic last_tick;

	assign last_tick = running_ff && t.fsub_tick && !t.scl_fall &&
		pre_ff == PRE_LAST && cnt_ff == t.period; // see [RULE12]
	assign t.overflow = ovf_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			running_ff <= 1'b0;
			pre_ff <= 5'h00;
			cnt_ff <= 6'h00;
		end else if (clk_en) begin
			if (t.stop || !t.en || last_tick) begin
				running_ff <= 1'b0; // see [RULE13] see [RULE14]
			end else if (t.start) begin
				running_ff <= 1'b1; // see [RULE11]
				pre_ff <= 5'h00;
				cnt_ff <= 6'h00;
			end else if (running_ff && t.scl_fall) begin
				pre_ff <= 5'h00; // see [RULE11]
				cnt_ff <= 6'h00;
			end else if (running_ff && t.fsub_tick) begin
				pre_ff <= pre_ff + 5'h01; // see [RULE17]
				if (pre_ff == PRE_LAST) begin
					cnt_ff <= cnt_ff + 6'h01;
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ovf_ff <= 1'b0;
		end else if (clk_en) begin
			ovf_ff <= last_tick && !t.stop && t.en;
		end
	end

	ovf_halts_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [RULE14]
		(clk_en && last_tick && !t.stop && t.en) |=> ovf_ff && !running_ff)
		else $error("counter did not halt on overflow");
endmodule : bus_timeout_counter
`default_nettype wire

// >>> verilog/i2c_slave_with_timeout.sv
// I2C slave engine with AXI4-Lite registers and bus time-out
`timescale 1ns/10ps
`default_nettype none
`include "i2c_slave_cfg.svh"
module i2c_slave_with_timeout #(
	parameter int AW = 8
) (
	// Clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	// AXI4-Lite write
	input wire logic [AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// I2C pins, open drain
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	// Slow time-out clock and interrupt request
	input wire logic fsub_clk,
	output logic sim_irq
);
	generate
		if (AW < 6) begin : g_aw_check
			$error("AW must be at least 6");
		end
	endgenerate

	// ----------------------------------------------------------------
	// Pin synchronisers and bus events
	// ----------------------------------------------------------------
	logic [2:0] sync1_ff, sync2_ff, dly_ff;
	logic scl_rise, scl_fall, start_ev, stop_ev, fsub_tick;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_ff <= 3'h7;
			sync2_ff <= 3'h7;
			dly_ff <= 3'h7;
		end else if (clk_en) begin
			sync1_ff <= {fsub_clk, sda_i, scl_i};
			sync2_ff <= sync1_ff;
			dly_ff <= sync2_ff;
		end
	end

	logic [7:0] ctrl1_ff;
	assign scl_rise = sync2_ff[0] && !dly_ff[0];
	assign scl_fall = !sync2_ff[0] && dly_ff[0];
	assign start_ev = ctrl1_ff[`C1_ENABLE] && sync2_ff[0] && dly_ff[0] &&
		!sync2_ff[1] && dly_ff[1];
	assign stop_ev = ctrl1_ff[`C1_ENABLE] && sync2_ff[0] && dly_ff[0] &&
		sync2_ff[1] && !dly_ff[1];
	assign fsub_tick = sync2_ff[2] && !dly_ff[2];

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	logic aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff;
	logic [AW-1:0] awaddr_ff;
	logic [7:0] wdata_ff;
	logic wstrb0_ff;
	logic [1:0] bresp_ff, rresp_ff;
	logic [31:0] rdata_ff;
	logic wr_go, ar_go;

	function automatic logic mapped(input logic [AW-1:0] a);
		mapped = (a[AW-1:5] == '0) && a[1:0] == 2'h0 &&
			a[4:0] <= `OFS_TIMEOUT;
	endfunction : mapped

	assign s_axi_awready = !aw_got_ff && !bvalid_ff;
	assign s_axi_wready = !w_got_ff && !bvalid_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rresp = rresp_ff;
	assign s_axi_rdata = rdata_ff;
	assign wr_go = aw_got_ff && w_got_ff && !bvalid_ff;
	assign ar_go = s_axi_arvalid && !rvalid_ff;

	logic wr_c1, wr_c2, wr_sa, wr_data, wr_toc, rd_data, data_acc;
	assign wr_c1 = wr_go && wstrb0_ff && mapped(awaddr_ff) &&
		awaddr_ff[4:0] == `OFS_CTRL_FIRST;
	assign wr_c2 = wr_go && wstrb0_ff && mapped(awaddr_ff) &&
		awaddr_ff[4:0] == `OFS_CTRL_SECOND;
	assign wr_sa = wr_go && wstrb0_ff && mapped(awaddr_ff) &&
		awaddr_ff[4:0] == `OFS_SLAVE_ADDR;
	assign wr_data = wr_go && wstrb0_ff && mapped(awaddr_ff) &&
		awaddr_ff[4:0] == `OFS_DATA;
	assign wr_toc = wr_go && wstrb0_ff && mapped(awaddr_ff) &&
		awaddr_ff[4:0] == `OFS_TIMEOUT;
	assign rd_data = ar_go && mapped(s_axi_araddr) &&
		s_axi_araddr[4:0] == `OFS_DATA;
	assign data_acc = wr_data || rd_data; // see [RULE10]

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= 2'h0;
			awaddr_ff <= '0;
			wdata_ff <= 8'h00;
			wstrb0_ff <= 1'b0;
		end else if (clk_en) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_ff <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_ff <= 1'b1;
				wdata_ff <= s_axi_wdata[7:0];
				wstrb0_ff <= s_axi_wstrb[0];
			end
			if (wr_go) begin
				aw_got_ff <= 1'b0;
				w_got_ff <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff <= mapped(awaddr_ff) ? 2'h0 : 2'h2;
			end else if (bvalid_ff && s_axi_bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0] saddr_ff, data_ff;
	logic rw_dir_ff, tx_sel_ff, addressed_ff, ack_rcvd_n_ff;
	logic ack_to_send_ff, busy_ff, toc_en_ff, toc_flag_ff;
	i2c_slave_pkg::period_t toc_per_ff;
	logic to_ovf, addr_match, rx_load, tx_done;
	logic [7:0] c2_view, toc_view;
	i2c_slave_pkg::slave_state_t state_ff;
	logic [7:0] shift_ff;
	logic [3:0] bitcnt_ff;
	logic sda_drv_ff, hold_ff;

	assign c2_view = {1'b0, addressed_ff, busy_ff, tx_sel_ff, ack_to_send_ff,
		rw_dir_ff, 1'b0, ack_rcvd_n_ff};
	assign toc_view = {toc_en_ff, toc_flag_ff, toc_per_ff};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rresp_ff <= 2'h0;
			rdata_ff <= 32'h0000_0000;
		end else if (clk_en) begin
			if (ar_go) begin
				rvalid_ff <= 1'b1;
				rresp_ff <= mapped(s_axi_araddr) ? 2'h0 : 2'h2;
				unique case (s_axi_araddr[4:0])
					`OFS_CTRL_FIRST: rdata_ff <= {24'h000000, ctrl1_ff};
					`OFS_CTRL_SECOND: rdata_ff <= {24'h000000, c2_view};
					`OFS_SLAVE_ADDR: rdata_ff <= {24'h000000, saddr_ff};
					`OFS_DATA: rdata_ff <= {24'h000000, data_ff};
					`OFS_TIMEOUT: rdata_ff <= {24'h000000, toc_view};
					default: rdata_ff <= 32'h0000_0000;
				endcase
			end else if (rvalid_ff && s_axi_rready) begin
				rvalid_ff <= 1'b0;
			end
		end
	end

	// Time-out leaves first control, address and data untouched
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl1_ff <= `C1_RESET;
			saddr_ff <= `SADDR_RESET;
			data_ff <= 8'h00;
		end else if (clk_en) begin
			if (wr_c1) ctrl1_ff <= wdata_ff;
			if (wr_sa) saddr_ff <= {wdata_ff[7:1], 1'b0};
			if (rx_load) begin
				data_ff <= shift_ff; // see [RULE9]
			end else if (wr_data) begin
				data_ff <= wdata_ff; // see [RULE9]
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || (clk_en && to_ovf)) begin
			{addressed_ff, busy_ff, tx_sel_ff} <= 3'h0; // see [RULE15]
			{ack_to_send_ff, rw_dir_ff, ack_rcvd_n_ff} <= 3'h0;
		end else if (clk_en) begin
			if (wr_c2) begin
				tx_sel_ff <= wdata_ff[`C2_TX_SELECT];
				ack_to_send_ff <= wdata_ff[`C2_ACK_TO_SEND];
			end
			if (start_ev) busy_ff <= 1'b1;
			else if (stop_ev) busy_ff <= 1'b0;
			if (start_ev || stop_ev) addressed_ff <= 1'b0;
			if (addr_match) begin
				addressed_ff <= 1'b1; // see [RULE19]
				rw_dir_ff <= shift_ff[0]; // see [RULE19]
				tx_sel_ff <= shift_ff[0]; // see [RULE1] see [RULE2] see [RULE5]
			end else if (data_acc) begin
				addressed_ff <= 1'b0;
			end
			if (state_ff == i2c_slave_pkg::ST_TX_ACK && scl_rise) begin
				ack_rcvd_n_ff <= sync2_ff[1]; // see [RULE20]
			end
		end
	end

	// Hardware set of the flag beats a clearing write in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{toc_en_ff, toc_flag_ff, toc_per_ff} <= `TOC_RESET; // see [RULE18]
		end else if (clk_en) begin
			if (wr_toc) begin
				toc_en_ff <= wdata_ff[`TOC_EN];
				toc_flag_ff <= wdata_ff[`TOC_FLAG]; // see [RULE16]
				toc_per_ff <= wdata_ff[5:0];
			end
			if (to_ovf) begin
				toc_en_ff <= 1'b0; // see [RULE14]
				toc_flag_ff <= 1'b1; // see [RULE14]
			end
		end
	end

	// ----------------------------------------------------------------
	// Slave engine
	// ----------------------------------------------------------------
	assign addr_match = state_ff == i2c_slave_pkg::ST_ADDR && scl_fall &&
		bitcnt_ff == `BYTE_BITS && shift_ff[7:1] == saddr_ff[7:1];
	assign rx_load = state_ff == i2c_slave_pkg::ST_RX && scl_fall &&
		bitcnt_ff == `BYTE_BITS;
	assign tx_done = state_ff == i2c_slave_pkg::ST_TX_ACK && scl_fall;

	always_ff @(posedge aclk) begin
		if (!aresetn || (clk_en && to_ovf)) begin
			state_ff <= i2c_slave_pkg::ST_IDLE;
			bitcnt_ff <= 4'h0;
			shift_ff <= 8'h00;
			sda_drv_ff <= 1'b0;
			hold_ff <= 1'b0;
		end else if (clk_en) begin
			if (data_acc) hold_ff <= 1'b0; // see [RULE10]
			if (wr_data && state_ff == i2c_slave_pkg::ST_TX) begin
				shift_ff <= wdata_ff; // see [RULE9]
				sda_drv_ff <= !wdata_ff[7];
			end
			if (start_ev) begin
				state_ff <= i2c_slave_pkg::ST_ADDR;
				bitcnt_ff <= 4'h0;
				sda_drv_ff <= 1'b0;
				hold_ff <= 1'b0;
			end else if (stop_ev) begin
				state_ff <= i2c_slave_pkg::ST_IDLE;
				sda_drv_ff <= 1'b0;
				hold_ff <= 1'b0;
			end else if (scl_rise) begin
				if (state_ff == i2c_slave_pkg::ST_ADDR ||
					state_ff == i2c_slave_pkg::ST_RX) begin
					shift_ff <= {shift_ff[6:0], sync2_ff[1]}; // see [RULE6]
					bitcnt_ff <= bitcnt_ff + 4'h1;
				end else if (state_ff == i2c_slave_pkg::ST_TX) begin
					bitcnt_ff <= bitcnt_ff + 4'h1;
				end
			end else if (scl_fall) begin
				unique case (state_ff)
					i2c_slave_pkg::ST_IDLE, i2c_slave_pkg::ST_WAIT_STOP: begin
						sda_drv_ff <= 1'b0;
					end
					i2c_slave_pkg::ST_ADDR: begin
						if (bitcnt_ff == `BYTE_BITS) begin
							// Foreign address: stay off the bus until STOP or a repeated START
							state_ff <= addr_match ? i2c_slave_pkg::ST_ADDR_ACK
								: i2c_slave_pkg::ST_WAIT_STOP; // see [RULE4]
							sda_drv_ff <= addr_match; // see [RULE3]
						end
					end
					i2c_slave_pkg::ST_ADDR_ACK: begin
						state_ff <= tx_sel_ff ? i2c_slave_pkg::ST_TX
							: i2c_slave_pkg::ST_RX; // see [RULE1] see [RULE2]
						bitcnt_ff <= 4'h0;
						sda_drv_ff <= 1'b0;
						hold_ff <= 1'b1; // see [RULE21]
					end
					i2c_slave_pkg::ST_RX: begin
						if (bitcnt_ff == `BYTE_BITS) begin
							state_ff <= i2c_slave_pkg::ST_RX_ACK;
							sda_drv_ff <= !ack_to_send_ff; // see [RULE7]
						end
					end
					i2c_slave_pkg::ST_RX_ACK: begin
						state_ff <= i2c_slave_pkg::ST_RX;
						bitcnt_ff <= 4'h0;
						sda_drv_ff <= 1'b0;
						hold_ff <= 1'b1; // see [RULE21]
					end
					i2c_slave_pkg::ST_TX: begin
						if (bitcnt_ff == `BYTE_BITS) begin
							state_ff <= i2c_slave_pkg::ST_TX_ACK;
							sda_drv_ff <= 1'b0;
						end else begin
							shift_ff <= {shift_ff[6:0], 1'b0}; // see [RULE6]
							sda_drv_ff <= !shift_ff[6];
						end
					end
					i2c_slave_pkg::ST_TX_ACK: begin
						bitcnt_ff <= 4'h0;
						if (ack_rcvd_n_ff) begin
							state_ff <= i2c_slave_pkg::ST_WAIT_STOP; // see [RULE8]
						end else begin
							state_ff <= i2c_slave_pkg::ST_TX;
							hold_ff <= 1'b1; // see [RULE21]
						end
					end
				endcase
			end
		end
	end

	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe = hold_ff; // see [RULE21]
	assign sda_oe = sda_drv_ff;

	// ----------------------------------------------------------------
	// Time-out counter and interrupt
	// ----------------------------------------------------------------
	timeout_if tmo ();
	assign tmo.start = addr_match; // see [RULE11]
	assign tmo.scl_fall = scl_fall;
	assign tmo.stop = stop_ev; // see [RULE13]
	assign tmo.en = toc_en_ff;
	assign tmo.fsub_tick = fsub_tick;
	assign tmo.period = toc_per_ff;
	assign to_ovf = tmo.overflow;

	bus_timeout_counter u_timeout (
		.aclk(aclk),
		.aresetn(aresetn),
		.clk_en(clk_en),
		.t(tmo.counter)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sim_irq <= 1'b0;
		end else if (clk_en) begin
			sim_irq <= addr_match || rx_load || tx_done || to_ovf; // see [RULE14]
		end
	end

	addr_ack_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [RULE3]
		(clk_en && addr_match && !to_ovf) |=> state_ff ==
		i2c_slave_pkg::ST_ADDR_ACK && sda_oe && addressed_ff)
		else $error("no acknowledge after matching address");
	dir_read_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [RULE5]
		(clk_en && addr_match && shift_ff[0] && !to_ovf) |=> tx_sel_ff &&
		rw_dir_ff && sim_irq)
		else $error("read direction did not select transmit");
	dir_write_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [RULE2]
		(clk_en && addr_match && !shift_ff[0] && !to_ovf) |=> !tx_sel_ff)
		else $error("write direction did not select receive");
	rx_ack_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [RULE7]
		(clk_en && rx_load && !to_ovf) |=> sda_oe == !$past(ack_to_send_ff))
		else $error("ninth-clock acknowledge level wrong");
	nack_release_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [RULE8]
		(state_ff == i2c_slave_pkg::ST_WAIT_STOP) |-> !sda_oe && !scl_oe)
		else $error("bus not released while waiting for stop");
	rx_store_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [RULE9]
		(clk_en && rx_load && !to_ovf) |=> data_ff == $past(shift_ff))
		else $error("received byte not stored");
	scl_release_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [RULE10]
		(clk_en && hold_ff && data_acc && !start_ev) |=> !scl_oe)
		else $error("data access did not release clock");
	tmo_flag_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [RULE14]
		(clk_en && to_ovf) |=> toc_flag_ff && !toc_en_ff &&
		state_ff == i2c_slave_pkg::ST_IDLE && c2_view == `C2_RESET)
		else $error("time-out effects missing");
endmodule : i2c_slave_with_timeout
`default_nettype wire

// >>> verif/i2c_master_model.sv
// Behavioural I2C bus master that drives the slave through open-drain pulls
`timescale 1ns/10ps
`default_nettype none
module i2c_master_model #(
	parameter int H = 20
) (
	// Clock
	input wire logic aclk,
	// Resolved bus lines
	input wire logic scl,
	input wire logic sda,
	// Pulls, high drives the line low
	output logic scl_pull,
	output logic sda_pull
);
	int stuck = 0;
	initial begin
		scl_pull = 1'b0;
		sda_pull = 1'b0;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask : cyc
	// Waits out clock stretching, but a hung slave is counted, not waited on
	task automatic rise();
		int n;
		n = 0;
		scl_pull <= 1'b0;
		cyc(1);
		while (scl !== 1'b1 && n < 100) begin
			cyc(1);
			n++;
		end
		if (n == 100) stuck++;
	endtask : rise
	task automatic start();
		cyc(1);
		sda_pull <= 1'b1;
		cyc(H);
		scl_pull <= 1'b1;
		cyc(H);
	endtask : start
	task automatic stop();
		sda_pull <= 1'b1;
		cyc(H);
		rise();
		cyc(H);
		sda_pull <= 1'b0;
		cyc(H);
	endtask : stop
	task automatic clk_bit(input logic b, output logic s);
		sda_pull <= ~b;
		cyc(H);
		rise();
		cyc(H / 2);
		s = sda;
		cyc(H / 2);
		scl_pull <= 1'b1;
		cyc(H);
	endtask : clk_bit
	task automatic byte_x(input logic [7:0] d, input logic last,
		output logic [7:0] q, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			clk_bit(d[i], q[i]);
		end
		clk_bit(last, ack);
	endtask : byte_x
endmodule : i2c_master_model
`default_nettype wire

// >>> verif/test_i2c_slave_with_timeout.sv
// Self-checking bench for the I2C slave with bus time-out
`timescale 1ns/10ps
`default_nettype none
`include "i2c_slave_cfg.svh"
module test_i2c_slave_with_timeout;
	localparam real FP = 40.2;
	localparam int TSEL = 3;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic fsub_clk = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, sim_irq;
	logic scl_oe, sda_oe, m_scl, m_sda, ack;
	logic [1:0] rresp, rresp_seen, bresp;
	logic scl_o, sda_o;
	logic [31:0] rdata;
	logic [31:0] irq_count = 32'h0;
	logic [7:0] q;
	wire logic scl_w, sda_w;
	int err_count = 0;
	int checks_done = 0;
	// Open-drain lines: low while either party pulls
	assign scl_w = !((scl_oe === 1'b1 && scl_o === 1'b0) || m_scl === 1'b1);
	assign sda_w = !((sda_oe === 1'b1 && sda_o === 1'b0) || m_sda === 1'b1);
	always #2.5 aclk = ~aclk;
	// Slow clock period not a multiple of aclk, so phases drift
	always #20.1 fsub_clk = ~fsub_clk;
	always @(posedge aclk) begin
		if (sim_irq === 1'b1) irq_count <= irq_count + 32'h1;
	end
	i2c_slave_with_timeout #(.AW(8)) DUT (
		.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe),
		.sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
		.fsub_clk(fsub_clk), .sim_irq(sim_irq)
	);
	i2c_master_model #(.H(20)) master (
		.aclk(aclk), .scl(scl_w), .sda(sda_w),
		.scl_pull(m_scl), .sda_pull(m_sda)
	);
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("Error at %0t ns: got %h, expected %h", $time, g, e);
		end
	endtask : chk
	task automatic axi_wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= {3'h0, a};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		// Offsets past the last register answer with a slave error
		chk(32'(bresp), (a > `OFS_TIMEOUT) ? 32'h2 : 32'h0);
	endtask : axi_wr
	task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
		@(posedge aclk);
		araddr <= {3'h0, a};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rresp_seen = rresp;
		rready <= 1'b0;
		chk(rdata, e);
	endtask : rd_chk
	task automatic end_of_test();
		$display("Checks %0d, errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_of_test
	task automatic test_regs();
		rd_chk(`OFS_CTRL_SECOND, 32'h0);
		rd_chk(`OFS_TIMEOUT, 32'h0);
		chk(32'(rresp_seen), 32'h0);
		axi_wr(`OFS_TIMEOUT, 32'hFF);
		rd_chk(`OFS_TIMEOUT, 32'hFF);
		rd_chk(5'h14, 32'h0);
		chk(32'(rresp_seen), 32'h2);
		axi_wr(5'h14, 32'h0);
		axi_wr(`OFS_TIMEOUT, 32'h0);
		axi_wr(`OFS_SLAVE_ADDR, 32'hB4);
		axi_wr(`OFS_CTRL_FIRST, 32'h1);
		$display("Test regs done");
	endtask : test_regs
	task automatic test_write();
		master.start();
		master.byte_x(8'hB6, 1'b1, q, ack);
		chk(32'(ack), 32'h1);
		master.stop();
		master.start();
		master.byte_x(8'hB4, 1'b1, q, ack);
		chk(32'(ack), 32'h0);
		chk(irq_count, 32'h1);
		repeat (10) @(posedge aclk);
		chk(32'(scl_oe), 32'h1);
		rd_chk(`OFS_CTRL_SECOND, 32'h60);
		rd_chk(`OFS_DATA, 32'h0);
		repeat (4) @(posedge aclk);
		chk(32'(scl_oe), 32'h0);
		master.byte_x(8'hC3, 1'b1, q, ack);
		chk(32'(ack), 32'h0);
		axi_wr(`OFS_CTRL_SECOND, 32'h08);
		rd_chk(`OFS_DATA, 32'hC3);
		master.byte_x(8'h3C, 1'b1, q, ack);
		chk(32'(ack), 32'h1);
		rd_chk(`OFS_DATA, 32'h3C);
		axi_wr(`OFS_CTRL_SECOND, 32'h0);
		master.stop();
		$display("Test write done");
	endtask : test_write
	task automatic test_read();
		axi_wr(`OFS_TIMEOUT, 32'h80);
		master.start();
		master.byte_x(8'hB5, 1'b1, q, ack);
		chk(32'(ack), 32'h0);
		rd_chk(`OFS_CTRL_SECOND, 32'h74);
		axi_wr(`OFS_DATA, 32'h96);
		master.byte_x(8'hFF, 1'b0, q, ack);
		chk(32'(q), 32'h96);
		rd_chk(`OFS_CTRL_SECOND, 32'h34);
		axi_wr(`OFS_DATA, 32'h5A);
		master.byte_x(8'hFF, 1'b1, q, ack);
		chk(32'(q), 32'h5A);
		repeat (4) @(posedge aclk);
		chk(32'({scl_oe, sda_oe}), 32'h0);
		rd_chk(`OFS_CTRL_SECOND, 32'h35);
		master.stop();
		// Three whole periods at the shortest setting
		repeat (3 * 32 * 9) @(posedge aclk);
		rd_chk(`OFS_TIMEOUT, 32'h80);
		$display("Test read done");
	endtask : test_read
	task automatic test_timeout();
		realtime t0, dt, lo, hi;
		int n;
		lo = (TSEL + 1) * 32 * FP - FP;
		hi = (TSEL + 1) * 32 * FP + 30.0;
		axi_wr(`OFS_TIMEOUT, 32'h83);
		master.start();
		master.byte_x(8'hB4, 1'b1, q, ack);
		// SCL fell 20 clocks ago; the counter saw it 3 clocks after that
		t0 = $realtime - 17 * 5.0;
		n = 0;
		while (sim_irq !== 1'b1 && n < 3000) begin
			@(posedge aclk);
			n++;
		end
		dt = $realtime - t0;
		chk(32'(dt > lo), 32'h1);
		chk(32'(dt < hi), 32'h1);
		rd_chk(`OFS_TIMEOUT, 32'h43);
		rd_chk(`OFS_CTRL_SECOND, 32'h0);
		rd_chk(`OFS_SLAVE_ADDR, 32'hB4);
		rd_chk(`OFS_CTRL_FIRST, 32'h1);
		chk(32'(scl_oe), 32'h0);
		axi_wr(`OFS_TIMEOUT, 32'h03);
		rd_chk(`OFS_TIMEOUT, 32'h03);
		master.stop();
		$display("Test timeout done");
	endtask : test_timeout
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		test_regs();
		test_write();
		test_read();
		test_timeout();
		chk(master.stuck, 32'h0);
		end_of_test();
	end
	// Roughly six times the expected length of the whole run
	initial begin
		#200000;
		err_count++;
		$display("Error at %0t ns: watchdog expired", $time);
		end_of_test();
	end
endmodule : test_i2c_slave_with_timeout
`default_nettype wire
